// file: logic/driver_status_map.svh
`ifndef DRIVER_STATUS_MAP_SVH
`define DRIVER_STATUS_MAP_SVH

// register indexes; byte address is four times the index
`define IDX_DRIVER_STATUS   8'h6F
`define IDX_CHOPPER_CONFIG  8'h6C
`define IDX_EVENT_STATUS    8'h78
`define IDX_EVENT_MASK      8'h79

// driver_status_word fields
`define BIT_HALTED          31
`define BIT_OPEN_B          30
`define BIT_OPEN_A          29
`define BIT_GND_B           28
`define BIT_GND_A           27
`define BIT_PREWARN         26
`define BIT_THERMAL         25
`define BIT_STALL           24
`define CS_HI               20
`define CS_LO               16
`define BIT_FULLSTEP        15
`define BIT_QUIET_PWM       14
`define BIT_SUP_B           13
`define BIT_SUP_A           12
`define LOAD_HI             9
`define LOAD_LO             0

// chopper config fields
`define CFG_OFF_TIME_HI     3
`define CFG_OFF_TIME_LO     0
`define CFG_LOAD_SPEED      4
`define CHOP_OFF_TIME_RESET 4'h0
`define LOAD_MEASURE_ZERO   10'h000

// bits that raise an event when they rise
`define EVENT_BITS          32'hFF003000

// standstill after this many cycles without a step pulse
`define STANDSTILL_CYCLES   1048576
`define STANDSTILL_WIDTH    21

`endif

// file: logic/driver_status_pkg.sv
package driver_status_pkg;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [9:0]  address;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} avalon_req_s;

	typedef struct packed {
		logic step_pulse;
		logic driver_disable_input;
		logic open_b;
		logic open_a;
		logic ground_short_b;
		logic ground_short_a;
		logic supply_short_b;
		logic supply_short_a;
		logic prewarn;
		logic overtemp;
	} bridge_pins_s;

	typedef struct packed {
		logic [9:0] load_measure_value;
		logic [4:0] current_scale;
		logic       fullstep_active;
		logic       quiet_pwm_active;
		logic       load_speed_stall;
	} chopper_state_s;

endpackage

// file: logic/standstill_timer.sv
`timescale 1ns/1ns
`include "driver_status_map.svh"

module standstill_timer
	import driver_status_pkg::*;
#(
	parameter int                      WIDTH  = `STANDSTILL_WIDTH,
	parameter logic [WIDTH-1:0]        CYCLES = WIDTH'(`STANDSTILL_CYCLES)
) (
	input  wire logic clock_in,
	input  wire logic nrst_in,
	input  wire logic step_in,
	output logic      halted_out
);

	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic             halted;
	} timer_s;

	timer_s st;
	timer_s next_st;

	always_comb begin
		next_st = st;
		if (step_in) begin
			next_st.count = '0;
			next_st.halted = 1'b0;
		end else if (!st.halted) begin
			next_st.count = st.count + WIDTH'(1);
			if (next_st.count == CYCLES) begin
				next_st.halted = 1'b1;
			end
		end
	end

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign halted_out = st.halted;

endmodule

// file: logic/driver_status_flags.sv
// Summary of operation
// RQ1: motor-halted bit 31 sets after 2^20 cycles without a step pulse.
// RQ2: open load phase B in bit 30, phase A in bit 29.
// RQ3: open-load flags only report; no protective action follows them.
// RQ4: short to ground sets bit 28 or 27 and disables the driver.
// RQ5: short flags stay latched until off time is zero or disable input.
// RQ6: thermal pre-warning bit 26 follows the threshold, shared by both bridges.
// RQ7: thermal limit bit 25 disables bridges until pre-warning also clears.
// RQ8: stall bit 24 on zero load value or stall in load-speed mode.
// RQ9: bits 20..16 show the actual current scale.
// RQ10: fullstep-active flag in bit 15.
// RQ11: bit 14 set while quiet voltage-mode PWM runs.
// RQ12: short to supply phase B sets bit 13, disables driver, latches.
// RQ13: short to supply phase A in bit 12, sense drop included.
// RQ14: bits 9..0 carry the load measurement, zero is highest load.
// RQ15: reserved bits read zero; reading has no side effect on flags.
`timescale 1ns/1ns
`include "driver_status_map.svh"

module driver_status_flags
	import driver_status_pkg::*;
#(
	parameter int                     STANDSTILL_WIDTH  = `STANDSTILL_WIDTH,
	parameter logic [STANDSTILL_WIDTH-1:0] STANDSTILL_CYCLES =
		STANDSTILL_WIDTH'(`STANDSTILL_CYCLES)
) (
	input  wire logic            clock_in,
	input  wire logic            nrst_in,
	input  wire avalon_req_s     bus_in,
	output logic                 waitrequest_out,
	output logic [31:0]          readdata_out,
	input  wire bridge_pins_s    pins_in,
	input  wire chopper_state_s  chopper_in,
	output logic                 driver_enable_out,
	output logic                 irq_out
);

	typedef struct packed {
		logic         ack;
		logic [31:0]  readdata;
		bridge_pins_s sync1;
		bridge_pins_s sync2;
		bridge_pins_s sync3;
		bridge_pins_s agreed;
		logic         step_prev;
		logic         gnd_a;
		logic         gnd_b;
		logic         sup_a;
		logic         sup_b;
		logic         thermal_limit;
		logic [31:0]  status_prev;
		logic [31:0]  event_status;
		logic [31:0]  event_mask;
		logic [3:0]   off_time;
		logic         load_speed_mode;
		logic         driver_enable;
	} state_s;

	state_s st;
	state_s next_st;

	logic        halted;
	logic        step_event;
	logic        request;
	logic        accept;
	logic        stall_now;
	logic        disabled_now;
	logic [31:0] status_word;
	logic [31:0] config_word;
	logic [31:0] wmask;
	logic [31:0] rising;

	// word index from an Avalon byte address
	function automatic logic [7:0] reg_index(input logic [9:0] address);
		reg_index = address[9:2];
	endfunction

	// expand byte enables into a bit mask
	function automatic logic [31:0] lane_mask(input logic [3:0] byteenable);
		lane_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
			{8{byteenable[1]}}, {8{byteenable[0]}}};
	endfunction

	assign request = bus_in.read | bus_in.write;
	// one wait cycle, then the answer edge
	assign accept = request & st.ack;
	assign waitrequest_out = request & ~st.ack;
	assign wmask = lane_mask(bus_in.byteenable);

	assign step_event = st.agreed.step_pulse & ~st.step_prev;

	standstill_timer #(
		.WIDTH  (STANDSTILL_WIDTH),
		.CYCLES (STANDSTILL_CYCLES)
	) u_standstill (
		.clock_in   (clock_in),
		.nrst_in    (nrst_in),
		.step_in    (step_event),
		.halted_out (halted)
	); // [RQ1]

	// driver counts as disabled by zero off time or the disable pin
	assign disabled_now = (st.off_time == `CHOP_OFF_TIME_RESET) |
		st.agreed.driver_disable_input; // [RQ5]

	assign stall_now = (chopper_in.load_measure_value == `LOAD_MEASURE_ZERO) |
		(st.load_speed_mode & chopper_in.load_speed_stall); // [RQ8]

	always_comb begin
		status_word = '0; // [RQ15]
		status_word[`BIT_HALTED] = halted; // [RQ1]
		status_word[`BIT_OPEN_B] = st.agreed.open_b; // [RQ2]
		status_word[`BIT_OPEN_A] = st.agreed.open_a; // [RQ2]
		status_word[`BIT_GND_B] = st.gnd_b; // [RQ4]
		status_word[`BIT_GND_A] = st.gnd_a; // [RQ4]
		status_word[`BIT_PREWARN] = st.agreed.prewarn; // [RQ6]
		status_word[`BIT_THERMAL] = st.thermal_limit; // [RQ7]
		status_word[`BIT_STALL] = stall_now; // [RQ8]
		status_word[`CS_HI:`CS_LO] = chopper_in.current_scale; // [RQ9]
		status_word[`BIT_FULLSTEP] = chopper_in.fullstep_active; // [RQ10]
		status_word[`BIT_QUIET_PWM] = chopper_in.quiet_pwm_active; // [RQ11]
		status_word[`BIT_SUP_B] = st.sup_b; // [RQ12]
		status_word[`BIT_SUP_A] = st.sup_a; // [RQ13]
		status_word[`LOAD_HI:`LOAD_LO] = chopper_in.load_measure_value; // [RQ14]
	end

	always_comb begin
		config_word = '0;
		config_word[`CFG_OFF_TIME_HI:`CFG_OFF_TIME_LO] = st.off_time;
		config_word[`CFG_LOAD_SPEED] = st.load_speed_mode;
	end

	assign rising = status_word & ~st.status_prev & `EVENT_BITS;

	always_comb begin
		next_st = st;

		// pin synchronisers: a change counts once stages two and three agree
		next_st.sync1 = pins_in;
		next_st.sync2 = st.sync1;
		next_st.sync3 = st.sync2;
		next_st.agreed = (st.sync2 & ~(st.sync2 ^ st.sync3)) |
			(st.agreed & (st.sync2 ^ st.sync3));
		next_st.step_prev = st.agreed.step_pulse;

		// short flags: clear while disabled, a new detection wins
		if (disabled_now) begin
			next_st.gnd_a = 1'b0; // [RQ5]
			next_st.gnd_b = 1'b0; // [RQ5]
			next_st.sup_a = 1'b0; // [RQ5]
			next_st.sup_b = 1'b0; // [RQ5]
		end
		if (st.agreed.ground_short_a) begin
			next_st.gnd_a = 1'b1; // [RQ4]
		end
		if (st.agreed.ground_short_b) begin
			next_st.gnd_b = 1'b1; // [RQ4]
		end
		if (st.agreed.supply_short_a) begin
			next_st.sup_a = 1'b1; // [RQ13]
		end
		if (st.agreed.supply_short_b) begin
			next_st.sup_b = 1'b1; // [RQ12]
		end

		// thermal limit holds until both thermal inputs are gone
		if (st.agreed.overtemp) begin
			next_st.thermal_limit = 1'b1; // [RQ7]
		end else if (!st.agreed.prewarn) begin
			next_st.thermal_limit = 1'b0; // [RQ7]
		end

		// open-load bits are left out on purpose: they only report
		next_st.driver_enable = ~(disabled_now | next_st.gnd_a | next_st.gnd_b |
			next_st.sup_a | next_st.sup_b | next_st.thermal_limit |
			st.agreed.overtemp); // [RQ3] [RQ4] [RQ7] [RQ12]

		// event capture
		next_st.status_prev = status_word;

		// bus slave
		next_st.ack = request & ~st.ack;
		if (request && !st.ack) begin
			if (bus_in.read) begin
				case (reg_index(bus_in.address))
					`IDX_DRIVER_STATUS: next_st.readdata = status_word; // [RQ15]
					`IDX_CHOPPER_CONFIG: next_st.readdata = config_word;
					`IDX_EVENT_STATUS: next_st.readdata = st.event_status;
					`IDX_EVENT_MASK: next_st.readdata = st.event_mask;
					default: next_st.readdata = '0;
				endcase
			end else begin
				next_st.readdata = '0;
			end
		end

		if (accept && bus_in.write) begin
			case (reg_index(bus_in.address))
				`IDX_CHOPPER_CONFIG: begin
					if (bus_in.byteenable[0]) begin
						next_st.off_time =
							bus_in.writedata[`CFG_OFF_TIME_HI:`CFG_OFF_TIME_LO];
						next_st.load_speed_mode = bus_in.writedata[`CFG_LOAD_SPEED];
					end
				end
				`IDX_EVENT_STATUS: begin
					next_st.event_status = st.event_status &
						~(bus_in.writedata & wmask);
				end
				`IDX_EVENT_MASK: begin
					next_st.event_mask = ((st.event_mask & ~wmask) |
						(bus_in.writedata & wmask)) & `EVENT_BITS;
				end
				default: begin
				end
			endcase
		end

		// a new event wins over a clear in the same cycle
		next_st.event_status = next_st.event_status | rising;
	end

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st <= '0;
			st.off_time <= `CHOP_OFF_TIME_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign readdata_out = st.readdata;
	assign driver_enable_out = st.driver_enable;
	assign irq_out = |(st.event_status & st.event_mask);

endmodule

// file: sim/driver_status_flags_props.sv
`timescale 1ns/1ns
module driver_status_flags_props
	import driver_status_pkg::*;
#(
	parameter int           W = 21,
	parameter logic [W-1:0] N = 16
) (
	input wire logic           clock_in,
	input wire logic           nrst_in,
	input wire avalon_req_s    bus_in,
	input wire logic           waitrequest_out,
	input wire logic [31:0]    readdata_out,
	input wire bridge_pins_s   pins_in,
	input wire chopper_state_s chopper_in,
	input wire logic           driver_enable_out,
	input wire logic           irq_out
);
	logic [7:0] idle;
	wire        st = bus_in.read && !waitrequest_out && bus_in.address == 10'h1BC;
	// cycles since the step pin was last high, zero until a first step
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			idle <= 8'h00;
		end else if (pins_in.step_pulse) begin
			idle <= 8'h01;
		end else if (idle != 8'h00 && idle != 8'hFF) begin
			idle <= idle + 8'h01;
		end
	end
	default clocking @(posedge clock_in); endclocking
	default disable iff (!nrst_in);
	bus_answer_a: assert property (
		$rose(bus_in.read | bus_in.write) |-> waitrequest_out ##1 !waitrequest_out)
		else $error("bus answer late");
	spare_zero_a: assert property (
		st |-> readdata_out[23:21] == 3'h0 && readdata_out[11:10] == 2'h0)
		else $error("spare bits set");
	live_fields_a: assert property (
		st |-> {readdata_out[9:0], readdata_out[20:14]} == $past(chopper_in[17:1]))
		else $error("live fields wrong");
	stall_zero_a: assert property (st && $past(chopper_in[17:8]) == 10'h0 |-> readdata_out[24])
		else $error("stall missing");
	halted_set_a: assert property (st && idle > N + 6 |-> readdata_out[31])
		else $error("halted missing");
	thermal_off_a: assert property (pins_in.overtemp [*5] |=> !driver_enable_out)
		else $error("hot but enabled");
	ground_off_a: assert property (
		(pins_in.ground_short_a || pins_in.ground_short_b) [*5] |=> !driver_enable_out)
		else $error("ground short but enabled");
	supply_off_a: assert property (pins_in.supply_short_b [*5] |=> !driver_enable_out)
		else $error("supply short but enabled");
	disable_off_a: assert property (pins_in.driver_disable_input [*5] |=> !driver_enable_out)
		else $error("disabled but enabled");
endmodule
bind driver_status_flags driver_status_flags_props #(.W(STANDSTILL_WIDTH), .N(STANDSTILL_CYCLES))
	u_driver_status_flags_props (.clock_in(clock_in), .nrst_in(nrst_in), .bus_in(bus_in),
	.waitrequest_out(waitrequest_out), .readdata_out(readdata_out), .pins_in(pins_in),
	.chopper_in(chopper_in), .driver_enable_out(driver_enable_out), .irq_out(irq_out));

// file: sim/bridge_model.sv
`timescale 1ns/1ns
module bridge_model
	import driver_status_pkg::*;
(
	input  wire logic           clock_in,
	input  wire logic           moving_in,
	input  wire logic [8:0]     faults_in,
	input  wire chopper_state_s chop_in,
	output bridge_pins_s        pins_out,
	output chopper_state_s      chop_out
);
	logic [1:0]     phase = 2'h0;
	bridge_pins_s   pins_q = '0;
	chopper_state_s chop_q = '0;
	assign pins_out = pins_q;
	assign chop_out = chop_q;
	// step pin high two cycles of four while the motor turns
	always @(posedge clock_in) begin
		phase <= moving_in ? phase + 2'h1 : 2'h0;
		pins_q <= {moving_in & phase[1], faults_in};
		chop_q <= chop_in;
	end
endmodule

// file: sim/test_driver_status_flags.sv
`timescale 1ns/1ns
module test_driver_status_flags;
	import driver_status_pkg::*;
	localparam logic [9:0]  S = 10'h1BC;
	localparam logic [9:0]  C = 10'h1B0;
	localparam logic [9:0]  E = 10'h1E0;
	localparam logic [31:0] B = 32'h0015C2A5;
	logic [31:0]    sb [4] = '{32'h10000000, 32'h08000000, 32'h00002000, 32'h00001000};
	logic           clock_in = 1'b0;
	logic           nrst_in = 1'b0;
	logic           moving = 1'b0;
	logic [8:0]     faults = 9'h000;
	avalon_req_s    bus = '0;
	chopper_state_s chop = '0;
	bridge_pins_s   pins;
	chopper_state_s chop_m;
	logic           waitreq;
	logic           drv_en;
	logic           irq;
	logic [31:0]    rdata;
	logic [31:0]    v;
	int             bad_count = 0;
	int             n_tests = 0;
	always #5 clock_in = ~clock_in;
	bridge_model u_bridge_model (.clock_in(clock_in), .moving_in(moving), .faults_in(faults),
		.chop_in(chop), .pins_out(pins), .chop_out(chop_m));
	driver_status_flags #(.STANDSTILL_CYCLES(21'd16)) u_driver_status_flags (
		.clock_in(clock_in), .nrst_in(nrst_in), .bus_in(bus), .waitrequest_out(waitreq),
		.readdata_out(rdata), .pins_in(pins), .chopper_in(chop_m),
		.driver_enable_out(drv_en), .irq_out(irq));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d bad %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
	endtask
	task automatic access(input logic w, input logic [9:0] a, input logic [31:0] d);
		@(posedge clock_in);
		bus <= '{!w, w, a, 4'hF, d};
		do @(posedge clock_in); while (waitreq !== 1'b0);
		v = rdata;
		bus <= '0;
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] e);
		access(1'b0, a, 32'h0);
		check(v, e);
	endtask
	initial begin
		tick(5);
		nrst_in <= 1'b1;
		check(drv_en, 32'h0);
		chop <= '{10'h2A5, 5'h15, 1'b1, 1'b1, 1'b0};
		moving <= 1'b1;
		tick(8);
		rd(S, B);
		chop.load_measure_value <= 10'h000;
		tick(3);
		rd(S, 32'h0115C000);
		access(1'b1, C, 32'h13);
		chop <= '{10'h2A5, 5'h15, 1'b1, 1'b1, 1'b1};
		tick(3);
		rd(S, B | 32'h01000000);
		check(drv_en, 32'h1);
		chop.load_speed_stall <= 1'b0;
		moving <= 1'b0;
		tick(30);
		rd(S, B | 32'h80000000);
		moving <= 1'b1;
		faults <= 9'h0C0;
		tick(8);
		rd(S, B | 32'h60000000);
		check(drv_en, 32'h1);
		faults <= 9'h000;
		access(1'b1, E, 32'hFFFFFFFF);
		access(1'b1, 10'h1E4, 32'h08000000);
		$display("fields test done");
		for (int i = 0; i < 4; i++) begin
			faults <= 9'h020 >> i;
			tick(8);
			check(drv_en, 32'h0);
			check(irq, 32'(i >= 1));
			faults <= 9'h000;
			tick(8);
			rd(S, B | sb[i]);
			if (i[0]) begin
				faults <= 9'h100;
				tick(8);
				faults <= 9'h000;
			end else begin
				access(1'b1, C, 32'h0);
				access(1'b1, C, 32'h13);
			end
			tick(8);
			rd(S, B);
			check(drv_en, 32'h1);
		end
		$display("shorts test done");
		faults <= 9'h003;
		tick(8);
		rd(S, B | 32'h06000000);
		check(drv_en, 32'h0);
		faults <= 9'h002;
		tick(8);
		rd(S, B | 32'h06000000);
		check(drv_en, 32'h0);
		faults <= 9'h000;
		tick(8);
		rd(S, B);
		check(drv_en, 32'h1);
		rd(E, 32'h1E003000);
		access(1'b1, E, 32'h08000000);
		tick(1);
		check(irq, 32'h0);
		rd(E, 32'h16003000);
		access(1'b1, 10'h3FC, 32'hFFFFFFFF);
		rd(10'h3FC, 32'h0);
		$display("thermal and events test done");
		tally_and_finish();
	end
	initial begin
		#100000;
		bad_count++;
		tally_and_finish();
	end
endmodule
